// ===== inc/tpcs_pkg.sv
package tpcs_pkg;

  // command byte framing, counted in serial clock rising edges
  localparam int unsigned CMD_BITS      = 8;
  localparam logic [3:0]  RX_CNT_CHAN   = 4'h4;  // edge 5 starts acquisition
  localparam logic [3:0]  RX_CNT_LAST   = 4'h7;  // edge 8 ends the byte
  localparam int unsigned ACQ_CLKS      = 3;
  localparam logic [1:0]  ACQ_LAST_EDGE = 2'h2;

  // field positions of the command byte
  localparam int unsigned CMD_SER_BIT   = 2;
  localparam int unsigned CMD_PD_LSB    = 0;

  // channel and power-down codes
  localparam logic [2:0]  CH_Y          = 3'h1;
  localparam logic [2:0]  CH_X          = 3'h5;
  localparam logic [1:0]  PD_IRQ        = 2'h0;
  localparam logic [1:0]  PD_ON         = 2'h3;

  // converter
  localparam int unsigned RES_W         = 12;
  localparam logic [3:0]  CONV_LAST     = 4'hB;  // 12 steps, one per edge
  localparam logic [3:0]  SAR_MSB       = 4'hB;

  // reset values
  localparam logic [1:0]  PD_RST        = 2'h0;
  localparam logic [2:0]  CH_RST        = 3'h0;
  localparam logic [3:0]  DRV_OFF       = 4'h0;

  // driver vector order {y_plus, y_minus, x_plus, x_minus}
  localparam logic [3:0]  DRV_Y         = 4'hC;
  localparam logic [3:0]  DRV_X         = 4'h3;

  typedef enum logic [1:0] {
    TPCS_IDLE,
    TPCS_ACQ,
    TPCS_CONV,
    TPCS_HOLD
  } tpcs_state_e;

  // channel code to panel drivers; other codes are plain inputs
  function automatic logic [3:0] tpcs_drv(input logic [2:0] chan);
    tpcs_drv = DRV_OFF;
    if (chan == CH_Y) begin
      tpcs_drv = DRV_Y;
    end else if (chan == CH_X) begin
      tpcs_drv = DRV_X;
    end
  endfunction

endpackage

// ===== inc/tpcs_sar_if.sv
`timescale 1ns/100ps
interface tpcs_sar_if;
  import tpcs_pkg::*;
  logic             start;
  logic             step;
  logic             comp;
  logic [RES_W-1:0] code;
  logic [RES_W-1:0] result;
  logic             done;

  modport ctrl (output start, output step, output comp,
                input code, input result, input done);
  modport sar  (input start, input step, input comp,
                output code, output result, output done);
endinterface

// ===== verilog/tpcs_sar.sv
`timescale 1ns/100ps
module tpcs_sar
  import tpcs_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_resetn,
  // sequencer side
  tpcs_sar_if.sar   sif
);

  logic [3:0] idx_ff;

  // one bit decided per step, msb first
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sif.code   <= '0;
      sif.result <= '0;
      sif.done   <= 1'b0;
      idx_ff     <= SAR_MSB;
    end else begin
      sif.done <= 1'b0;
      if (sif.start) begin
        sif.code          <= '0;
        sif.code[SAR_MSB] <= 1'b1;
        idx_ff            <= SAR_MSB;
      end else if (sif.step) begin
        sif.code[idx_ff] <= sif.comp;
        if (idx_ff != 4'h0) begin
          sif.code[idx_ff - 4'h1] <= 1'b1;
          idx_ff                  <= idx_ff - 4'h1;
        end else begin
          sif.result    <= {sif.code[RES_W-1:1], sif.comp};
          sif.done      <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== verilog/tpcs_seq.sv
`timescale 1ns/100ps
module tpcs_seq
  import tpcs_pkg::*;
(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_resetn,
  // serial command port from the host
  input  wire logic             i_cs_n,
  input  wire logic             i_sclk,
  input  wire logic             i_din,
  // comparator: panel voltage at or above trial code
  input  wire logic             i_cmp_hi,
  // panel drivers {y_plus, y_minus, x_plus, x_minus}
  output logic      [3:0]       o_drv,
  // analog front end control
  output logic                  o_sample_track,
  output logic                  o_ref_ratio,
  output logic                  o_powered,
  output logic                  o_touch_detect_irq_en,
  output logic      [RES_W-1:0] o_sar_code,
  // conversion result
  output logic                  o_converting,
  output logic      [RES_W-1:0] o_result,
  output logic                  o_result_valid
);

  tpcs_sar_if sif ();

  tpcs_state_e state_ff;
  logic        sclk_q_ff;
  logic [3:0]  rx_cnt_ff;
  logic [6:0]  rx_sh_ff;
  logic [2:0]  chan_ff;
  logic        ser_ff;
  logic [1:0]  pd_ff;
  logic [3:0]  conv_cnt_ff;
  logic [1:0]  acq_edge_ff;
  logic        sclk_rise;
  logic        acq_go;
  logic        byte_end;
  logic        conv_end;

  // inputs are synchronous; a rising serial clock paces everything
  assign sclk_rise = i_sclk & ~sclk_q_ff;
  assign acq_go    = sclk_rise & ~i_cs_n & (rx_cnt_ff == RX_CNT_CHAN);
  assign byte_end  = sclk_rise & ~i_cs_n & (rx_cnt_ff == RX_CNT_LAST);
  assign conv_end  = sclk_rise & (state_ff == TPCS_CONV)
                   & (conv_cnt_ff == CONV_LAST);

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_q_ff <= 1'b0;
    end else begin
      sclk_q_ff <= i_sclk;
    end
  end

  // command receiver: waits for a start bit, then counts seven more
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_cnt_ff <= 4'h0;
      rx_sh_ff  <= '0;
    end else if (i_cs_n) begin
      rx_cnt_ff <= 4'h0;
    end else if (sclk_rise) begin
      if (rx_cnt_ff != 4'h0 || i_din) begin
        rx_sh_ff  <= {rx_sh_ff[5:0], i_din};
        rx_cnt_ff <= (rx_cnt_ff == RX_CNT_LAST) ? 4'h0 : rx_cnt_ff + 4'h1;
      end
    end
  end

  // sequencer and the settings latched from each command
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff    <= TPCS_IDLE;
      chan_ff     <= CH_RST;
      ser_ff      <= 1'b0;
      pd_ff       <= PD_RST;
      conv_cnt_ff <= 4'h0;
      acq_edge_ff <= 2'h0;
    end else begin
      unique case (state_ff)
        TPCS_IDLE, TPCS_HOLD: begin
          if (acq_go) begin
            state_ff    <= TPCS_ACQ;
            chan_ff     <= rx_sh_ff[2:0];
            acq_edge_ff <= 2'h0;
          end else if (state_ff == TPCS_HOLD && rx_cnt_ff == 4'h0) begin
            state_ff <= TPCS_IDLE;   // follow-on command abandoned
          end
        end
        TPCS_ACQ: begin
          if (byte_end) begin
            // third edge of acquisition: hold and convert
            state_ff    <= TPCS_CONV;
            ser_ff      <= rx_sh_ff[CMD_SER_BIT-1];
            pd_ff       <= {rx_sh_ff[0], i_din};
            conv_cnt_ff <= 4'h0;
          end else if (rx_cnt_ff == 4'h0) begin
            state_ff <= TPCS_IDLE;   // select dropped mid-byte
          end else if (sclk_rise) begin
            acq_edge_ff <= acq_edge_ff + 2'h1;
          end
        end
        TPCS_CONV: begin
          if (conv_end) begin
            // a differential follow-on already arriving keeps the panel
            if (!ser_ff && rx_cnt_ff != 4'h0) begin
              state_ff <= TPCS_HOLD;
            end else begin
              state_ff <= TPCS_IDLE;
            end
          end else if (sclk_rise) begin
            conv_cnt_ff <= conv_cnt_ff + 4'h1;
          end
        end
      endcase
    end
  end

  // panel drivers; registered so the pins never glitch on decode
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_drv <= DRV_OFF;
    end else if ((state_ff == TPCS_IDLE || state_ff == TPCS_HOLD)
                 && acq_go) begin
      o_drv <= tpcs_drv(rx_sh_ff[2:0]);
    end else if (state_ff == TPCS_ACQ && byte_end
                 && rx_sh_ff[CMD_SER_BIT-1]) begin
      o_drv <= DRV_OFF;
    end else if (state_ff == TPCS_ACQ && rx_cnt_ff == 4'h0) begin
      o_drv <= DRV_OFF;
    end else if (state_ff == TPCS_HOLD && rx_cnt_ff == 4'h0) begin
      o_drv <= DRV_OFF;
    end else if (conv_end && (ser_ff || rx_cnt_ff == 4'h0)) begin
      o_drv <= DRV_OFF;
    end
  end

  // front end: track, reference, bias and touch interrupt enable
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sample_track        <= 1'b0;
      o_ref_ratio           <= 1'b0;
      o_powered             <= 1'b0;
      o_touch_detect_irq_en <= 1'b1;
      o_converting          <= 1'b0;
    end else begin
      o_sample_track <= (state_ff == TPCS_ACQ);
      o_converting   <= (state_ff == TPCS_CONV);
      o_ref_ratio    <= (state_ff == TPCS_CONV) && !ser_ff;
      // bias stays up in idle only for the always-on code
      o_powered      <= (state_ff != TPCS_IDLE) || (pd_ff == PD_ON);
      o_touch_detect_irq_en <= (state_ff == TPCS_IDLE)
                             && (pd_ff == PD_IRQ);
    end
  end

  // successive approximation, one step per serial edge of conversion
  assign sif.start  = (state_ff == TPCS_ACQ) && byte_end;
  assign sif.step   = (state_ff == TPCS_CONV) && sclk_rise;
  assign sif.comp   = i_cmp_hi;
  assign o_sar_code = sif.code;

  tpcs_sar u_sar (
    .i_core_clk (i_core_clk),
    .i_resetn   (i_resetn),
    .sif        (sif)
  );

  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_result       <= '0;
      o_result_valid <= 1'b0;
    end else begin
      o_result_valid <= sif.done;
      if (sif.done) begin
        o_result <= sif.result;
      end
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  drv_on_acq_a: assert property (
    (state_ff == TPCS_ACQ) |-> (o_drv == tpcs_drv(chan_ff)))
    else $error("drivers not on during acquisition");

  acq_three_a: assert property (
    (state_ff == TPCS_ACQ && byte_end) |-> (acq_edge_ff == ACQ_LAST_EDGE))
    else $error("acquisition not three serial clocks");

  se_off_a: assert property (
    (state_ff == TPCS_CONV && ser_ff) |-> (o_drv == DRV_OFF))
    else $error("single-ended drivers on in conversion");

  idle_after_a: assert property (
    (conv_end && rx_cnt_ff == 4'h0) |=> (state_ff == TPCS_IDLE)
    ##1 (o_drv == DRV_OFF && o_converting == 1'b0))
    else $error("no power down after conversion");

  diff_on_a: assert property (
    (state_ff == TPCS_CONV && !ser_ff) |-> (o_drv == tpcs_drv(chan_ff)))
    else $error("differential drivers dropped");

  ref_sel_a: assert property (
    (state_ff == TPCS_CONV) ##1 (state_ff == TPCS_CONV)
    |-> (o_ref_ratio == !ser_ff))
    else $error("reference selection wrong");

  keep_on_a: assert property (
    (conv_end && !ser_ff && rx_cnt_ff != 4'h0)
    |=> (o_drv == $past(o_drv)) [*2])
    else $error("follow-on drivers not kept");

  chan_latch_a: assert property (
    ((state_ff == TPCS_IDLE || state_ff == TPCS_HOLD) && acq_go)
    |=> (chan_ff == $past(rx_sh_ff[2:0]) && state_ff == TPCS_ACQ))
    else $error("channel not latched at acquisition");

  irq_en_a: assert property (
    (state_ff == TPCS_IDLE && pd_ff == PD_IRQ) [*2]
    |-> o_touch_detect_irq_en)
    else $error("touch interrupt not enabled");

  y_axis_a: assert property (
    (state_ff == TPCS_ACQ && chan_ff == CH_Y) |-> (o_drv == DRV_Y))
    else $error("y drivers wrong");

  se_conv_c:  cover property (conv_end && ser_ff);
  diff_hold_c: cover property ((state_ff == TPCS_HOLD) ##[1:200]
                               (state_ff == TPCS_ACQ));
  result_c:   cover property (o_result_valid);
  irq_idle_c: cover property (o_touch_detect_irq_en && $past(o_converting));

endmodule

// ===== dv/tpcs_host.sv
`timescale 1ns/100ps
module tpcs_host
  import tpcs_pkg::*;
(
  // clock
  input  wire logic             i_core_clk,
  // converter trial code
  input  wire logic [RES_W-1:0] i_sar_code,
  // serial command port
  output logic                  o_cs_n,
  output logic                  o_sclk,
  output logic                  o_din,
  // panel comparator
  output logic                  o_cmp_hi
);
  logic [RES_W-1:0] level;

  // panel voltage against the trial code
  assign o_cmp_hi = (level >= i_sar_code);

  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
    level  = '0;
  end

  // data line is not held outside frames, so nothing may rely on it
  always @(negedge i_core_clk) begin
    if (o_cs_n) o_din <= ~o_din;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask

  // chip select, changed only off the falling edge like the serial clock and data pins
  task automatic frame(input logic on);
    o_cs_n = ~on;
  endtask

  // voltage at the touch point; the comparator follows it
  task automatic set_level(input logic [RES_W-1:0] v);
    level = v;
  endtask

  // slow serial clock so the panel settles in the window; idles low
  task automatic pulse(input logic b);
    o_din = b;
    wait_n(3);
    o_sclk = 1'b1;
    wait_n(3);
    o_sclk = 1'b0;
  endtask

  // command bits n0..n1-1, msb first, byte carries all fields
  task automatic bits(input logic [7:0] b, input int n0, input int n1);
    for (int i = n0; i < n1; i++) pulse(b[7-i]);
  endtask

  // conversion clocks with the receiver left empty
  task automatic clocks(input int n);
    repeat (n) pulse(1'b0);
  endtask
endmodule

// ===== dv/touch_panel_conversion_sequencer_bench.sv
`timescale 1ns/100ps
module touch_panel_conversion_sequencer_bench;
  import tpcs_pkg::*;
  logic             i_core_clk = 1'b0;
  logic             i_resetn   = 1'b0;
  logic             cs_n;
  logic             sclk;
  logic             din;
  logic             cmp_hi;
  logic [3:0]       drv;
  logic             track;
  logic             ratio;
  logic             powered;
  logic             irq_en;
  logic [RES_W-1:0] sar_code;
  logic             converting;
  logic [RES_W-1:0] result;
  logic             valid;
  logic [RES_W-1:0] got;
  int               bad_count   = 0;
  int               checks_done = 0;
  int               nres        = 0;

  always #5 i_core_clk = ~i_core_clk;

  tpcs_seq u_dut (
    .i_core_clk            (i_core_clk),
    .i_resetn              (i_resetn),
    .i_cs_n                (cs_n),
    .i_sclk                (sclk),
    .i_din                 (din),
    .i_cmp_hi              (cmp_hi),
    .o_drv                 (drv),
    .o_sample_track        (track),
    .o_ref_ratio           (ratio),
    .o_powered             (powered),
    .o_touch_detect_irq_en (irq_en),
    .o_sar_code            (sar_code),
    .o_converting          (converting),
    .o_result              (result),
    .o_result_valid        (valid)
  );

  tpcs_host u_host (
    .i_core_clk (i_core_clk),
    .i_sar_code (sar_code),
    .o_cs_n     (cs_n),
    .o_sclk     (sclk),
    .o_din      (din),
    .o_cmp_hi   (cmp_hi)
  );

  // catch the one-cycle result pulse
  always @(posedge i_core_clk) begin
    if (valid === 1'b1) begin
      nres <= nres + 1;
      got  <= result;
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [3:0] exp_drv(input logic [2:0] ch);
    return (ch == CH_Y) ? DRV_Y : ((ch == CH_X) ? DRV_X : DRV_OFF);
  endfunction

  // one command; follow leaves the next byte to start mid-conversion
  task automatic conv(input logic [2:0] ch, input logic ser,
                      input logic [1:0] pd, input logic [11:0] lvl,
                      input bit chained, input bit follow);
    logic [7:0] b;
    int         n0;
    b = {1'b1, ch, 1'b0, ser, pd};
    u_host.frame(1'b1);
    u_host.wait_n(1);
    u_host.bits(b, 0, 4);
    if (chained) chk("held drv", drv, exp_drv(ch));
    u_host.set_level(lvl);
    n0 = nres;
    u_host.bits(b, 4, 5);
    chk("acq drv", drv, exp_drv(ch));
    u_host.bits(b, 5, 7);
    chk("track", track, 1'b1);
    u_host.bits(b, 7, 8);
    chk("track end", track, 1'b0);
    chk("conv drv", drv, ser ? DRV_OFF : exp_drv(ch));
    chk("ratio", ratio, !ser);
    chk("converting", converting, 1'b1);
    // first of a same-channel pair is unsettled: host drops it
    if (follow) begin
      u_host.clocks(8);
      return;
    end
    u_host.clocks(12);
    for (int k = 0; k < 40 && nres == n0; k++) u_host.wait_n(1);
    if (nres == n0) begin
      bad_count++;
      complete_run();
    end
    chk("result", got, lvl);
    u_host.wait_n(2);
    chk("idle drv", drv, DRV_OFF);
    chk("idle conv", converting, 1'b0);
    chk("irq en", irq_en, pd == PD_IRQ);
    chk("powered", powered, pd == PD_ON);
    u_host.frame(1'b0);
    u_host.wait_n(2);
  endtask

  initial begin
    logic [2:0]  ch;
    logic        ser;
    logic [1:0]  pd;
    logic [11:0] lvl;
    void'($urandom(32'h795A58B5));
    repeat (10) @(negedge i_core_clk);
    i_resetn = 1'b1;
    u_host.wait_n(2);
    chk("rst irq", irq_en, 1'b1);
    conv(CH_Y, 1'b1, PD_IRQ, 12'h000, 1'b0, 1'b0);
    conv(CH_X, 1'b0, PD_ON, 12'hFFF, 1'b0, 1'b0);
    conv(CH_X, 1'b0, 2'h1, 12'h5A3, 1'b0, 1'b1);
    conv(CH_X, 1'b0, 2'h2, 12'h3C6, 1'b1, 1'b0);
    // abort mid-acquisition by raising chip select
    u_host.frame(1'b1);
    u_host.wait_n(1);
    u_host.bits(8'h94, 0, 5);
    u_host.frame(1'b0);
    u_host.wait_n(3);
    chk("abort drv", drv, DRV_OFF);
    chk("abort track", track, 1'b0);
    // reset in mid-acquisition: every output back at rest
    u_host.frame(1'b1);
    u_host.wait_n(1);
    u_host.bits(8'hD0, 0, 6);
    chk("pre rst drv", drv, DRV_X);
    i_resetn = 1'b0;
    u_host.wait_n(2);
    chk("rst drv", drv, DRV_OFF);
    chk("rst track", track, 1'b0);
    chk("rst code", sar_code, 12'h000);
    chk("rst result", result, 12'h000);
    chk("rst powered", powered, 1'b0);
    chk("rst conv", converting, 1'b0);
    u_host.frame(1'b0);
    i_resetn = 1'b1;
    u_host.wait_n(2);
    chk("rst irq again", irq_en, 1'b1);
    chk("rst idle drv", drv, DRV_OFF);
    repeat (10) begin
      ch  = 3'($urandom);
      ser = 1'($urandom);
      pd  = 2'($urandom);
      lvl = 12'($urandom);
      conv(ch, ser, pd, lvl, 1'b0, 1'b0);
    end
    complete_run();
  end
endmodule
